// ---- pkg/pdio_pkg.sv ----
`default_nettype none
package pdio_pkg;
  // io window of the third base address register
  localparam int unsigned    PDIO_ADDR_W       = 32;
  localparam int unsigned    PDIO_DATA_W       = 32;
  localparam int unsigned    PDIO_WIN_BITS     = 6;
  localparam int unsigned    PDIO_BAR_INDEX    = 2;
  // register offsets inside the window
  localparam logic [5:0]     PDIO_OFS_PORT     = 6'h00;
  localparam logic [5:0]     PDIO_OFS_READBACK = 6'h0c;
  localparam logic [5:0]     PDIO_OFS_CARD_ID  = 6'h3c;
  // field layout
  localparam int unsigned    PDIO_PORT_W       = 16;
  localparam int unsigned    PDIO_ID_W         = 4;
  localparam int unsigned    PDIO_ID_LSB       = 0;
  localparam int unsigned    PDIO_CH_DEFAULT   = 16;
  // reset values
  localparam logic [15:0]    PDIO_OUT_RESET    = 16'h0000;
  localparam logic [31:0]    PDIO_RDATA_RESET  = 32'h0000_0000;
  // answer timing: read data and ack one clock after the request
  localparam int unsigned    PDIO_ACK_LATENCY  = 1;
  localparam int unsigned    PDIO_SYNC_STAGES  = 2;
endpackage
`default_nettype wire

// ---- logic/pdio_sync.sv ----
`default_nettype none
// two-flop synchroniser for pin levels, one chain per bit
module pdio_sync
  import pdio_pkg::*;
#(
  parameter int unsigned WIDTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_r;
      logic hold_r;
      // first stage is read only by the second one
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_r <= 1'b0;
          hold_r <= 1'b0;
        end else begin
          meta_r <= async_in[i];
          hold_r <= meta_r;
        end
      end
      assign sync_out[i] = hold_r;
    end
  endgenerate
endmodule
`default_nettype wire

// ---- logic/pdio_port.sv ----
`default_nettype none
module pdio_port
  import pdio_pkg::*;
#(
  parameter int unsigned CH_COUNT     = PDIO_CH_DEFAULT,
  parameter bit          HAS_READBACK = 1'b1
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // base of the io window, from configuration space
  input  wire logic [PDIO_ADDR_W-1:0] bar2_base,
  // host io access
  input  wire logic                   io_req,
  input  wire logic                   io_we,
  input  wire logic [PDIO_ADDR_W-1:0] io_addr,
  input  wire logic [3:0]             io_be,
  input  wire logic [PDIO_DATA_W-1:0] io_wdata,
  output logic      [PDIO_DATA_W-1:0] io_rdata,
  output logic                        io_ack,
  output logic                        io_hit,
  // card pins
  input  wire logic [CH_COUNT-1:0]    isolated_inputs,
  input  wire logic [PDIO_ID_W-1:0]   board_id_switch,
  output logic      [CH_COUNT-1:0]    output_drive
);
  localparam int unsigned NBYTES = (CH_COUNT + 7) / 8;

  logic [CH_COUNT-1:0]    in_sync;
  logic [PDIO_ID_W-1:0]   id_sync;
  logic [CH_COUNT-1:0]    out_r;
  logic [CH_COUNT-1:0]    out_nxt;
  logic [PDIO_DATA_W-1:0] rdata_r;
  logic [PDIO_DATA_W-1:0] rdata_nxt;
  logic                   ack_r;
  logic                   hit_r;

  pdio_sync #(.WIDTH(CH_COUNT)) u_in_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (isolated_inputs),
    .sync_out (in_sync)
  );

  pdio_sync #(.WIDTH(PDIO_ID_W)) u_id_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (board_id_switch),
    .sync_out (id_sync)
  );

  // compare against the live base so a host rebase takes effect at once
  wire       win_hit  = io_addr[PDIO_ADDR_W-1:PDIO_WIN_BITS]
                        == bar2_base[PDIO_ADDR_W-1:PDIO_WIN_BITS];
  wire [5:0] offset   = io_addr[PDIO_WIN_BITS-1:0];
  // offsets are dword aligned; ignore byte address bits so byte reads still land
  wire [5:0] ofs_word = {offset[5:2], 2'b00};
  wire       sel_port = win_hit && (ofs_word == PDIO_OFS_PORT);
  wire       sel_rb   = win_hit && HAS_READBACK && (ofs_word == PDIO_OFS_READBACK);
  wire       sel_id   = win_hit && HAS_READBACK && (ofs_word == PDIO_OFS_CARD_ID);
  wire       do_write = io_req && io_we && sel_port;
  wire       do_read  = io_req && !io_we && win_hit;

  wire [PDIO_PORT_W-1:0] in_word = PDIO_PORT_W'(in_sync);
  wire [PDIO_PORT_W-1:0] rb_word = PDIO_PORT_W'(out_r);
  wire [PDIO_DATA_W-1:0] id_word = PDIO_DATA_W'(id_sync) << PDIO_ID_LSB;

  // only lanes that exist on this build take data; a byte write on the
  // 16 channel build updates just its own byte
  genvar b;
  generate
    for (b = 0; b < NBYTES; b++) begin : g_lane
      localparam int unsigned LO = b * 8;
      localparam int unsigned HI = (LO + 8 > CH_COUNT) ? CH_COUNT - 1 : LO + 7;
      assign out_nxt[HI:LO] = (do_write && io_be[b]) ? io_wdata[HI:LO]
                                                     : out_r[HI:LO];
    end
  endgenerate

  // the upper card id bits read as zero rather than floating
  assign rdata_nxt = !do_read ? rdata_r                                   :
                     sel_port ? PDIO_DATA_W'(in_word)                     :
                     sel_rb   ? PDIO_DATA_W'(rb_word)                     :
                     sel_id   ? id_word                                   :
                                PDIO_RDATA_RESET;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_r <= CH_COUNT'(PDIO_OUT_RESET);
    end else begin
      out_r <= out_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= PDIO_RDATA_RESET;
      ack_r   <= 1'b0;
      hit_r   <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      ack_r   <= io_req;
      hit_r   <= io_req && win_hit;
    end
  end

  assign io_rdata     = rdata_r;
  assign io_ack       = ack_r;
  assign io_hit       = hit_r;
  assign output_drive = out_r;
endmodule
`default_nettype wire

// ---- verif/pdio_port_monitor.sv ----
`default_nettype none
module pdio_port_monitor #(parameter int unsigned CH_COUNT = 16) (
  // watched ports
  input wire logic clk, rst, io_req, io_we, io_ack, io_hit,
  input wire logic [3:0] io_be, board_id_switch,
  input wire logic [31:0] bar2_base, io_addr, io_wdata, io_rdata,
  input wire logic [CH_COUNT-1:0] isolated_inputs, output_drive
);
  timeunit 1ns / 1ps;
  wire h = io_req && io_addr[31:6] == bar2_base[31:6];
  wire rd = h && !io_we;
  wire wr = h && io_we && io_addr[5:2] == 4'h0;
  wire [3:0] o = io_addr[5:2];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // pins held still across the two-flop synchroniser
  sequence pin_s; ($stable(isolated_inputs) && $stable(board_id_switch))[*3]; endsequence
  ack_hit_a: assert property (1 |=> io_ack == $past(io_req) && io_hit == $past(h))
    else $error("ack");
  in_read_a: assert property (pin_s ##0 rd && o == 4'h0 |=>
    io_rdata == 32'($past(isolated_inputs))) else $error("input");
  word_write_a: assert property (wr && io_be[1:0] == 2'h3 |=>
    output_drive == $past(io_wdata[15:0])) else $error("word");
  byte_write_a: assert property (wr && io_be == 4'h1 |=>
    output_drive == {$past(output_drive[15:8]), $past(io_wdata[7:0])}) else $error("byte");
  readback_a: assert property (rd && o == 4'h3 |=>
    io_rdata == 32'($past(output_drive)) && $stable(output_drive)) else $error("readback");
  card_id_a: assert property (pin_s ##0 rd && o == 4'hf |=>
    io_rdata[3:0] == $past(board_id_switch)) else $error("id");
  ro_write_a: assert property (io_req && !wr |=> $stable(output_drive))
    else $error("ro");
  undecoded_a: assert property (rd && !(o inside {4'h0, 4'h3, 4'hf}) |=> io_rdata == 0)
    else $error("undecoded");
endmodule
`default_nettype wire

// ---- verif/pdio_host.sv ----
`default_nettype none
module pdio_host (
  // host bus
  input wire logic clk, io_hit,
  input wire logic [31:0] io_rdata,
  output logic io_req, io_we,
  output logic [3:0] io_be,
  output logic [31:0] io_addr, io_wdata
);
  timeunit 1ns / 1ps;
  initial {io_req, io_we, io_be, io_addr, io_wdata} = '0;
  // no lanes means a read; any set lane makes a write of just those lanes
  task automatic acc(input logic [3:0] b, input logic [31:0] a, d,
                     output logic [31:0] r, output logic h);
    @(negedge clk);
    {io_req, io_we, io_be, io_addr, io_wdata} = {1'b1, |b, b, a, d};
    @(negedge clk);
    r = io_rdata;
    h = io_hit;
    // released lines flip so stale values never look fresh
    {io_req, io_addr, io_wdata} = {1'b0, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// ---- verif/pdio_port_bench.sv ----
`default_nettype none
module pdio_port_bench;
  timeunit 1ns / 1ps;
  logic clk = 1'b0, rst = 1'b1, io_req, io_we, io_ack, io_hit, h;
  logic [3:0] io_be, board_id_switch = 4'h9;
  logic [15:0] isolated_inputs = 16'h0, output_drive;
  logic [31:0] bar2_base = 32'he000, io_addr, io_wdata, io_rdata, r;
  int fails = 0, n_compared = 0;
  initial forever #2.5 clk = ~clk;
  pdio_host u_pdio_host (.*);
  pdio_port u_pdio_port (.*);
  task automatic io(input logic [3:0] b, input logic [7:0] o, input logic [31:0] d, m,
                    input bit x = 1'b1);
    u_pdio_host.acc(b, bar2_base + o, d, r, h);
    n_compared++;
    if (h !== x || x && b == 4'h0 && (r & m) !== d) begin
      fails++;
      $display("Error %0t: offset %h read %h", $time, o, r);
    end
  endtask
  task automatic t_out;
    io(4'h0, 8'h0c, 32'h0, '1);
    io(4'h3, 8'h00, 32'hffff_a5c3, '1);
    io(4'h1, 8'h00, 32'h5a, '1);
    io(4'h3, 8'h0c, 32'h0, '1);
    io(4'h0, 8'h0c, 32'ha55a, '1);
    $display("t_out done");
  endtask
  task automatic t_pins;
    isolated_inputs = 16'h3c96;
    repeat (3) @(negedge clk);
    io(4'h0, 8'h00, 32'h3c96, '1);
    io(4'h0, 8'h3c, 32'h9, 32'hf);
    io(4'h0, 8'h20, 32'h0, '1);
    $display("t_pins done");
  endtask
  task automatic t_map;
    bar2_base = 32'hd040;
    io(4'h0, 8'h0c, 32'ha55a, '1);
    io(4'h0, 8'h40, 32'h0, '1, 1'b0);
    $display("t_map done");
  endtask
  task automatic summarize;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    t_out;
    t_pins;
    t_map;
    summarize;
  end
  initial begin
    #2000;
    fails++;
    summarize;
  end
endmodule
bind pdio_port pdio_port_monitor #(.CH_COUNT(CH_COUNT)) u_pdio_port_monitor (.*);
`default_nettype wire
